// file: hdl/adcr_serial_port.sv
`timescale 1ns/1ps
`include "adcr_defs.svh"


module adcr_serial_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic cs_n_i,
  output logic shared_output_line_o,
  output logic shared_output_line_oe_o,
  output logic result_ready_n_o,
  // Converter core
  input wire logic conv_done_i,
  input wire logic [15:0] conv_data_i,
  input wire logic powerdown_i,
  input wire logic cfg_clear_i,
  output adcr_pkg::adcr_cfg_s cfg_o,
  output logic filter_restart_o
);

  // ----------------------------------------------------------------
  // Pin synchronisation and byte reception
  // ----------------------------------------------------------------
  adcr_pkg::adcr_pins_s pins_raw;
  adcr_pkg::adcr_pins_s pins_s;
  logic rise;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [2:0] bit_idx;

  assign pins_raw = '{sclk: sclk_i, din: din_i, cs_n: cs_n_i};

  adcr_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pins_i(pins_raw),
    .pins_o(pins_s)
  );

  adcr_rx_byte u_rx (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pins_i(pins_s),
    .rise_o(rise),
    .byte_done_o(byte_done),
    .byte_o(rx_byte),
    .bit_idx_o(bit_idx)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adcr_pkg::adcr_in_state_e state_q;
  adcr_pkg::adcr_cmd_s cmd;
  logic [7:0] cfg_q [4];
  logic [15:0] buf_q;
  logic pending_q;
  logic [2:0] busy_left_q;
  logic rd_regs_q;
  logic [1:0] rd_addr_q;
  logic [2:0] wr_left_q;
  logic [1:0] wr_addr_q;
  logic [15:0] out_sr_q;
  logic [4:0] out_left_q;
  logic [3:0] tail_left_q;
  logic direct_q;
  logic show_q;
  logic bit_q;
  logic ready_sel;
  logic decode_ok;
  logic cmd_result;
  logic cmd_reg_read;
  logic cmd_reg_write;
  logic next_reg_byte;
  logic direct_start;
  logic take;
  logic last_write;

  assign cmd = adcr_pkg::adcr_cmd_s'(rx_byte);
  assign ready_sel = cfg_q[`ADCR_REG_CURRENT_ROUTING_AND_READY][`ADCR_READY_SEL_BIT];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Decoding runs on every byte boundary outside busy and write phases,
  // so it also runs alongside a plain result read. An all-zero byte
  // matches no opcode, which is what lets a host read undisturbed.
  assign decode_ok = byte_done & (state_q == adcr_pkg::ADCR_DECODE);
  assign cmd_result = decode_ok & (cmd.op == `ADCR_OP_READ_RESULT);
  assign cmd_reg_read = decode_ok & (cmd.op == `ADCR_OP_REG_READ);
  assign cmd_reg_write = decode_ok & (cmd.op == `ADCR_OP_REG_WRITE);
  assign next_reg_byte = byte_done & (state_q == adcr_pkg::ADCR_BUSY) & rd_regs_q &
                         (busy_left_q > 3'h1);
  assign last_write = byte_done & (state_q == adcr_pkg::ADCR_WRITE) & (wr_left_q == 3'h1);

  // A plain read starts only at a byte boundary of an idle frame.
  assign direct_start = rise & pending_q & (state_q == adcr_pkg::ADCR_DECODE) &
                        (out_left_q == 5'h00) & (tail_left_q == 4'h0) &
                        (bit_idx == 3'h0) & ~cmd_result & ~cmd_reg_read;
  assign take = cmd_result | direct_start;

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || pins_s.cs_n) begin
      state_q <= adcr_pkg::ADCR_DECODE;
      busy_left_q <= 3'h0;
      rd_regs_q <= 1'b0;
      rd_addr_q <= 2'h0;
      wr_left_q <= 3'h0;
      wr_addr_q <= 2'h0;
    end else if (byte_done) begin
      unique case (state_q)
        adcr_pkg::ADCR_DECODE: begin
          if (cmd_result) begin
            state_q <= adcr_pkg::ADCR_BUSY;
            busy_left_q <= `ADCR_RESULT_BYTES;
            rd_regs_q <= 1'b0;
          end else if (cmd_reg_read) begin
            state_q <= adcr_pkg::ADCR_BUSY;
            busy_left_q <= {1'b0, cmd.cnt} + 3'h1;
            rd_regs_q <= 1'b1;
            rd_addr_q <= cmd.addr;
          end else if (cmd_reg_write) begin
            state_q <= adcr_pkg::ADCR_WRITE;
            wr_left_q <= {1'b0, cmd.cnt} + 3'h1;
            wr_addr_q <= cmd.addr;
          end
        end
        adcr_pkg::ADCR_WRITE: begin
          wr_left_q <= wr_left_q - 3'h1;
          wr_addr_q <= wr_addr_q + 2'h1;
          if (wr_left_q == 3'h1) begin
            state_q <= adcr_pkg::ADCR_DECODE;
          end
        end
        adcr_pkg::ADCR_BUSY: begin
          busy_left_q <= busy_left_q - 3'h1;
          if (next_reg_byte) begin
            rd_addr_q <= rd_addr_q + 2'h1;
          end
          if (busy_left_q == 3'h1) begin
            state_q <= adcr_pkg::ADCR_DECODE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Power-down deliberately has no path into this process, so the
  // settings survive it untouched.
  for (genvar r = 0; r < 4; r++) begin : g_cfg
    always_ff @(posedge clk_i) begin
      if (sys_rst_i || cfg_clear_i) begin
        cfg_q[r] <= `ADCR_CFG_RESET;
      end else if (byte_done && state_q == adcr_pkg::ADCR_WRITE &&
                   wr_addr_q == 2'(r)) begin
        cfg_q[r] <= rx_byte;
      end
    end
  end

  assign cfg_o = '{current_routing_and_ready_config: cfg_q[3],
                   reference_and_current_config: cfg_q[2],
                   rate_and_conversion_config: cfg_q[1],
                   input_and_gain_config: cfg_q[0]};

  // A write closes with a filter restart; none is issued while powered
  // down, since the core would have nothing to restart.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      filter_restart_o <= 1'b0;
    end else begin
      filter_restart_o <= last_write & ~powerdown_i;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer and readiness
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      buf_q <= 16'h0000;
    end else if (conv_done_i) begin
      buf_q <= conv_data_i;
    end
  end

  // A result that lands while an older one is being taken keeps the
  // flag set, so the ready pin stays low after the read.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pending_q <= 1'b0;
    end else if (conv_done_i) begin
      pending_q <= 1'b1;
    end else if (take) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result_ready_n_o <= 1'b1;
    end else begin
      result_ready_n_o <= ~pending_q;
    end
  end

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || pins_s.cs_n) begin
      out_sr_q <= 16'h0000;
      out_left_q <= 5'h00;
      tail_left_q <= 4'h0;
      direct_q <= 1'b0;
      show_q <= 1'b0;
      bit_q <= 1'b0;
    end else if (cmd_result) begin
      // Any plain read still in flight is dropped here.
      out_sr_q <= buf_q;
      out_left_q <= `ADCR_RESULT_BITS;
      tail_left_q <= 4'h0;
      direct_q <= 1'b0;
    end else if (cmd_reg_read) begin
      out_sr_q <= {cfg_q[cmd.addr], 8'h00};
      out_left_q <= `ADCR_REG_BITS;
      tail_left_q <= 4'h0;
      direct_q <= 1'b0;
    end else if (next_reg_byte) begin
      out_sr_q <= {cfg_q[rd_addr_q + 2'h1], 8'h00};
      out_left_q <= `ADCR_REG_BITS;
    end else if (direct_start) begin
      bit_q <= buf_q[15];
      out_sr_q <= {buf_q[14:0], 1'b0};
      out_left_q <= `ADCR_RESULT_BITS - 5'h01;
      direct_q <= 1'b1;
      show_q <= 1'b1;
    end else if (rise) begin
      if (out_left_q != 5'h00) begin
        bit_q <= out_sr_q[15];
        out_sr_q <= {out_sr_q[14:0], 1'b0};
        out_left_q <= out_left_q - 5'h01;
        show_q <= 1'b1;
        if (out_left_q == 5'h01 && direct_q) begin
          tail_left_q <= `ADCR_TAIL_LOW_CLKS;
        end
      end else if (tail_left_q != 4'h0) begin
        // Low for eight clocks; the idle level takes over afterwards.
        bit_q <= 1'b0;
        tail_left_q <= tail_left_q - 4'h1;
        show_q <= 1'b1;
        direct_q <= 1'b0;
      end else begin
        show_q <= 1'b0;
        direct_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared output line
  // ----------------------------------------------------------------
  // Between transfers the line mirrors readiness when that mode is set,
  // otherwise it rests high. The enable follows the synchronised select,
  // costing a few system clocks of latency against the pin.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      shared_output_line_o <= 1'b1;
      shared_output_line_oe_o <= 1'b0;
    end else begin
      shared_output_line_oe_o <= ~pins_s.cs_n;
      if (pins_s.cs_n) begin
        shared_output_line_o <= 1'b1;
      end else if (show_q) begin
        shared_output_line_o <= bit_q;
      end else if (ready_sel) begin
        shared_output_line_o <= ~pending_q;
      end else begin
        shared_output_line_o <= 1'b1;
      end
    end
  end

endmodule

// file: hdl/adcr_defs.svh
`ifndef ADCR_DEFS_SVH
`define ADCR_DEFS_SVH

// ----------------------------------------------------------------
// Command byte layout and opcodes
// ----------------------------------------------------------------
`define ADCR_OP_MSB 7
`define ADCR_OP_LSB 4
`define ADCR_ADDR_MSB 3
`define ADCR_ADDR_LSB 2
`define ADCR_CNT_MSB 1
`define ADCR_CNT_LSB 0
`define ADCR_OP_READ_RESULT 4'h1
`define ADCR_OP_REG_READ 4'h2
`define ADCR_OP_REG_WRITE 4'h4

// ----------------------------------------------------------------
// Configuration register offsets, reset value and fields
// ----------------------------------------------------------------
`define ADCR_REG_INPUT_AND_GAIN 2'h0
`define ADCR_REG_RATE_AND_CONVERSION 2'h1
`define ADCR_REG_REFERENCE_AND_CURRENT 2'h2
`define ADCR_REG_CURRENT_ROUTING_AND_READY 2'h3
`define ADCR_CFG_RESET 8'h00
`define ADCR_READY_SEL_BIT 1

// ----------------------------------------------------------------
// Transfer counts
// ----------------------------------------------------------------
`define ADCR_RESULT_BITS 5'h10
`define ADCR_RESULT_BYTES 3'h2
`define ADCR_REG_BITS 5'h08
`define ADCR_TAIL_LOW_CLKS 4'h8
`define ADCR_BYTE_LAST_BIT 3'h7

`endif

// file: hdl/adcr_pkg.sv
package adcr_pkg;

  typedef enum logic [2:0] {
    ADCR_DECODE = 3'b001,
    ADCR_WRITE = 3'b010,
    ADCR_BUSY = 3'b100
  } adcr_in_state_e;

  typedef struct packed {
    logic [3:0] op;
    logic [1:0] addr;
    logic [1:0] cnt;
  } adcr_cmd_s;

  typedef struct packed {
    logic sclk;
    logic din;
    logic cs_n;
  } adcr_pins_s;

  typedef struct packed {
    logic [7:0] current_routing_and_ready_config;
    logic [7:0] reference_and_current_config;
    logic [7:0] rate_and_conversion_config;
    logic [7:0] input_and_gain_config;
  } adcr_cfg_s;

endpackage

// file: hdl/adcr_sync.sv
`timescale 1ns/1ps

module adcr_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Pins
  input wire adcr_pkg::adcr_pins_s pins_i,
  output adcr_pkg::adcr_pins_s pins_o
);

  // Chip select idles high so a reset never looks like a selected frame.
  localparam logic [2:0] RST_VAL = 3'h1;

  logic [2:0] meta_q;
  logic [2:0] sync_q;

  for (genvar i = 0; i < 3; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        meta_q[i] <= RST_VAL[i];
        sync_q[i] <= RST_VAL[i];
      end else begin
        meta_q[i] <= pins_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign pins_o = sync_q;

endmodule

// file: hdl/adcr_rx_byte.sv
`timescale 1ns/1ps
`include "adcr_defs.svh"

module adcr_rx_byte (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Synchronised pins
  input wire adcr_pkg::adcr_pins_s pins_i,
  // Edge and byte events
  output logic rise_o,
  output logic byte_done_o,
  output logic [7:0] byte_o,
  output logic [2:0] bit_idx_o
);

  logic sclk_prev_q;
  logic [6:0] sr_q;
  logic fall;

  assign fall = sclk_prev_q & ~pins_i.sclk;
  assign rise_o = ~sclk_prev_q & pins_i.sclk & ~pins_i.cs_n;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= pins_i.sclk;
    end
  end

  // Input bits are taken on falling edges only.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || pins_i.cs_n) begin
      sr_q <= 7'h00;
      bit_idx_o <= 3'h0;
      byte_o <= 8'h00;
      byte_done_o <= 1'b0;
    end else begin
      byte_done_o <= 1'b0;
      if (fall) begin
        sr_q <= {sr_q[5:0], pins_i.din};
        bit_idx_o <= bit_idx_o + 3'h1;
        if (bit_idx_o == `ADCR_BYTE_LAST_BIT) begin
          byte_o <= {sr_q, pins_i.din};
          byte_done_o <= 1'b1;
        end
      end
    end
  end

endmodule

// file: bench/adcr_serial_port_props.sv
`timescale 1ns/1ps

module adcr_serial_port_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Watched ports
  input wire logic cs_n_i,
  input wire logic conv_done_i,
  input wire logic powerdown_i,
  input wire logic cfg_clear_i,
  input wire logic shared_output_line_o,
  input wire logic shared_output_line_oe_o,
  input wire logic result_ready_n_o,
  input wire adcr_pkg::adcr_cfg_s cfg_o,
  input wire logic filter_restart_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Six cycles cover the two synchroniser stages plus the output flop.
  property p_oe_off;
    cs_n_i [*6] |-> !shared_output_line_oe_o && shared_output_line_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("line driven while deselected");
  property p_oe_on;
    !cs_n_i [*6] |-> shared_output_line_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("line not driven while selected");
  property p_rdy_set;
    conv_done_i |-> ##[1:3] !result_ready_n_o;
  endproperty
  a_rdy_set: assert property (p_rdy_set)
    else $error("ready pin missed a new result");
  property p_rdy_cause;
    $fell(result_ready_n_o) |-> $past(conv_done_i) || $past(conv_done_i, 2);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause)
    else $error("ready pin fell without a result");
  property p_rst_pulse;
    filter_restart_o |=> !filter_restart_o;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("filter restart longer than one cycle");
  property p_rst_pd;
    powerdown_i && $past(powerdown_i) |-> !filter_restart_o;
  endproperty
  a_rst_pd: assert property (p_rst_pd)
    else $error("filter restart during power-down");
  property p_clear;
    cfg_clear_i |-> ##[1:3] cfg_o == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("registers not cleared");
  property p_cfg_hold;
    (cs_n_i && !cfg_clear_i) [*8] |-> $stable(cfg_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("registers changed without a command");

  c_ready: cover property (conv_done_i ##[1:3] !result_ready_n_o);
  c_restart: cover property ($rose(filter_restart_o));
  c_clear: cover property (cfg_clear_i);
endmodule

bind adcr_serial_port adcr_serial_port_props u_props (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .cs_n_i(cs_n_i),
  .conv_done_i(conv_done_i),
  .powerdown_i(powerdown_i),
  .cfg_clear_i(cfg_clear_i),
  .shared_output_line_o(shared_output_line_o),
  .shared_output_line_oe_o(shared_output_line_oe_o),
  .result_ready_n_o(result_ready_n_o),
  .cfg_o(cfg_o),
  .filter_restart_o(filter_restart_o)
);

// file: bench/adcr_host_model.sv
`timescale 1ns/1ps

module adcr_host_model (
  // Clock
  input wire logic clk_i,
  // Serial pins
  input wire logic line_i,
  output adcr_pkg::adcr_pins_s pins_o
);
  // The clock idles low and only moves inside a selected frame.
  initial pins_o = '{1'b0, 1'b0, 1'b1};

  task automatic sel(input logic v);
    pins_o.cs_n <= v;
    repeat (8) @(posedge clk_i);
  endtask

  // Half period of ten cycles leaves the line settled long before sampling.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins_o.sclk <= 1'b1;
      pins_o.din <= tx[i];
      repeat (10) @(posedge clk_i);
      rx[i] = line_i;
      pins_o.sclk <= 1'b0;
      repeat (10) @(posedge clk_i);
    end
    // A spare edge keeps the next byte from writing din in this same step.
    pins_o.din <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// file: bench/adcr_serial_port_tb.sv
`timescale 1ns/1ps
`include "adcr_defs.svh"

`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end

module adcr_serial_port_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic conv_done_i = 1'b0;
  logic [15:0] conv_data_i = 16'h0000;
  logic powerdown_i = 1'b0;
  logic cfg_clear_i = 1'b0;
  adcr_pkg::adcr_pins_s pins;
  adcr_pkg::adcr_cfg_s cfg;
  logic line;
  logic oe;
  logic rdy_n;
  logic restart;
  logic miso;
  int errors = 0;
  int tests_run = 0;
  int restarts = 0;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;

  always #50 clk_i = ~clk_i;
  // A released line shows the inverse of its last value, never a kind guess.
  assign miso = oe ? line : ~line;
  always @(posedge clk_i) if (restart === 1'b1) restarts <= restarts + 1;

  adcr_host_model host (.clk_i(clk_i), .line_i(miso), .pins_o(pins));
  adcr_serial_port dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(pins.sclk),
    .din_i(pins.din), .cs_n_i(pins.cs_n), .shared_output_line_o(line),
    .shared_output_line_oe_o(oe), .result_ready_n_o(rdy_n), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .powerdown_i(powerdown_i), .cfg_clear_i(cfg_clear_i),
    .cfg_o(cfg), .filter_restart_o(restart));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conv(input logic [15:0] d);
    conv_data_i <= d;
    conv_done_i <= 1'b1;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] v [4];
    v = '{8'hA5, 8'h3C, 8'h0F, 8'h02};
    `CHK("cfg", 32'h0, cfg)
    `CHK("oe", 1'b0, oe)
    host.sel(1'b0);
    host.xfer({`ADCR_OP_REG_WRITE, 4'h3}, b0);
    for (int i = 0; i < 4; i++) host.xfer(v[i], b0);
    `CHK("cfg", 32'h020F3CA5, cfg)
    `CHK("restarts", 1, restarts)
    host.xfer({`ADCR_OP_REG_READ, 4'h3}, b0);
    for (int i = 0; i < 4; i++) begin
      host.xfer(8'h00, b0);
      `CHK("reg", v[i], b0)
    end
    host.sel(1'b1);
    $display("done regs");
  endtask

  task automatic t_plain;
    conv(16'hBEEF);
    `CHK("ready", 1'b0, rdy_n)
    host.sel(1'b0);
    `CHK("line", 1'b0, line)
    host.xfer(8'h00, b0);
    host.xfer(8'h00, b1);
    `CHK("result", 16'hBEEF, {b0, b1})
    `CHK("ready", 1'b1, rdy_n)
    host.xfer(8'h00, b0);
    host.xfer(8'h00, b1);
    `CHK("tail", 16'h00FF, {b0, b1})
    host.sel(1'b1);
    host.sel(1'b0);
    `CHK("line", 1'b1, line)
    host.sel(1'b1);
    $display("done plain");
  endtask

  task automatic t_rdata;
    conv(16'h1234);
    host.sel(1'b0);
    host.xfer({`ADCR_OP_READ_RESULT, 4'h0}, b0);
    host.xfer(8'h00, b0);
    conv(16'h5678);
    host.xfer(8'h00, b1);
    `CHK("rdata", 16'h1234, {b0, b1})
    `CHK("ready", 1'b0, rdy_n)
    host.xfer({`ADCR_OP_READ_RESULT, 4'h0}, b0);
    host.xfer(8'h23, b0);
    host.xfer(8'h00, b1);
    `CHK("rdata", 16'h5678, {b0, b1})
    `CHK("ready", 1'b1, rdy_n)
    host.sel(1'b1);
    $display("done rdata");
  endtask

  task automatic t_abort;
    conv(16'h1E1E);
    host.sel(1'b0);
    host.xfer(8'h20, b0);
    host.xfer(8'h00, b1);
    `CHK("abort", 16'h1EA5, {b0, b1})
    host.sel(1'b1);
    conv(16'hC33C);
    host.sel(1'b0);
    host.xfer(8'h00, b0);
    host.xfer(8'h20, b1);
    host.xfer(8'h00, b2);
    `CHK("last", 24'hC33CA5, {b0, b1, b2})
    host.sel(1'b1);
    $display("done abort");
  endtask

  task automatic t_wr_pd;
    int r;
    r = restarts;
    conv(16'h6B6B);
    host.sel(1'b0);
    host.xfer(8'h4C, b0);
    host.xfer(8'h06, b1);
    `CHK("result", 16'h6B6B, {b0, b1})
    `CHK("restarts", r + 1, restarts)
    host.sel(1'b1);
    powerdown_i <= 1'b1;
    host.sel(1'b0);
    host.xfer(8'h40, b0);
    host.xfer(8'h77, b0);
    host.sel(1'b1);
    `CHK("cfg", 32'h060F3C77, cfg)
    `CHK("restarts", r + 1, restarts)
    powerdown_i <= 1'b0;
    cfg_clear_i <= 1'b1;
    @(posedge clk_i);
    cfg_clear_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("cfg", 32'h0, cfg)
    $display("done wr_pd");
  endtask

  initial begin
    #3000000;
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    t_regs();
    t_plain();
    t_rdata();
    t_abort();
    t_wr_pd();
    report_and_stop();
  end
endmodule
